// [verilog/fgr_pkg.sv]
package fgr_pkg;
  localparam logic [7:0] ADDR_CHARGE = 8'h21;
  localparam logic [7:0] ADDR_MV_HIGH = 8'h22;
  localparam logic [7:0] ADDR_MV_LOW = 8'h23;
  localparam logic [7:0] ADDR_CONTROL = 8'h24;
  localparam logic [7:0] ADDR_CLEAR = 8'h25;

  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SLEEP_BIT = 1;
  localparam int CTRL_PERIOD_BIT = 2;
  localparam int CLEAR_STROBE_BIT = 7;
  localparam int MV_LOW_LSB = 3;
  localparam int MV_SPLIT = 5;

  localparam logic [2:0] CONTROL_RESET = 3'h0;
  localparam logic [6:0] CHARGE_RESET = 7'h00;
  localparam logic [12:0] MV_RESET = 13'h0000;
  localparam logic [6:0] CHARGE_MAX = 7'h64;
  localparam logic [7:0] READ_ZERO = 8'h00;

  localparam longint CLK_HZ = 100_000_000;
  localparam longint SLEEP_SHORT_MIN = 5;
  localparam longint SLEEP_LONG_MIN = 20;
  localparam logic [39:0] SLEEP_SHORT_CYC = 40'(SLEEP_SHORT_MIN * 60 * CLK_HZ);
  localparam logic [39:0] SLEEP_LONG_CYC = 40'(SLEEP_LONG_MIN * 60 * CLK_HZ);
endpackage

// [verilog/fgr_regs.sv]
`timescale 1ns/100ps
// Functional notes
// [RL1] Charge register holds a read-only percentage in bits 6:0, limited 0..100.
// [RL2] High voltage register shows measurement bits 12:5, read-only.
// [RL3] Low voltage register shows bits 4:0 in 7:3; bits 2:0 read zero.
// [RL4] Host computes millivolts as high times 32 plus low divided by 8.
// [RL5] Control bit 0 enables the gauge; resets to 0.
// [RL6] Control bit 1 selects sleep mode when set; resets to 0.
// [RL7] Control bit 2 picks sleep update interval: 0 five, 1 twenty minutes.
// [RL8] Writing 1 to clear bit 7 zeroes charge and both voltage registers; a measurement arriving in the same cycle is stored instead.
// [RL9] Clear strobe lasts one cycle, reads zero, writing 0 does nothing.
// [RL10] Unused bits ignore writes and read zero; read-only registers ignore writes.
module fgr_regs #(
  parameter logic [39:0] SLEEP_SHORT_CYC = fgr_pkg::SLEEP_SHORT_CYC,
  parameter logic [39:0] SLEEP_LONG_CYC = fgr_pkg::SLEEP_LONG_CYC
) (
  input wire logic clk_sys, // 100 MHz system clock
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic [7:0] reg_addr, // Register address from serial port
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic reg_rd, // Read strobe, one cycle
  output logic [7:0] reg_rdata, // Read data, valid with reg_rvalid
  output logic reg_rvalid, // Read data valid pulse
  input wire logic meas_valid, // New measurement pulse from gauge core
  input wire logic [6:0] meas_charge, // Measured charge percent
  input wire logic [12:0] meas_mv, // Measured battery millivolts
  output logic gauge_enable, // Gauge on
  output logic sleep_mode, // Sleep mode selected
  output logic sleep_period_long, // Twenty minute sleep interval
  output logic clear_pulse, // Clear written last cycle; results zeroed unless meas_valid came with it
  output logic sleep_update // Sleep-mode update request pulse
);
  logic [6:0] charge_percent_reg;
  logic [12:0] battery_mv_reg;
  logic [2:0] gauge_control_reg;
  logic [39:0] sleep_count_reg;
  logic wr_control;
  logic clear_hit;
  logic [39:0] sleep_limit;

  function automatic logic [6:0] clamp_charge(input logic [6:0] v);
    clamp_charge = (v > fgr_pkg::CHARGE_MAX) ? fgr_pkg::CHARGE_MAX : v;
  endfunction

  assign wr_control = reg_wr && (reg_addr == fgr_pkg::ADDR_CONTROL);
  // [RL9] Only a written one strobes
  assign clear_hit = reg_wr && (reg_addr == fgr_pkg::ADDR_CLEAR) &&
                     reg_wdata[fgr_pkg::CLEAR_STROBE_BIT];
  // [RL7] Interval select
  assign sleep_limit = gauge_control_reg[fgr_pkg::CTRL_PERIOD_BIT] ?
                       SLEEP_LONG_CYC : SLEEP_SHORT_CYC;

  // [RL5] Control bits stored
  // [RL6] Sleep select stored
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gauge_control_reg <= fgr_pkg::CONTROL_RESET;
    end else if (wr_control) begin
      gauge_control_reg <= reg_wdata[2:0];
    end
  end

  // [RL8] Results cleared, but a measurement
  // arriving in the same cycle wins so it is not lost
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      charge_percent_reg <= fgr_pkg::CHARGE_RESET;
      battery_mv_reg <= fgr_pkg::MV_RESET;
    end else if (meas_valid) begin
      // [RL1] Percent limited to 100
      charge_percent_reg <= clamp_charge(meas_charge);
      battery_mv_reg <= meas_mv;
    end else if (clear_hit) begin
      charge_percent_reg <= fgr_pkg::CHARGE_RESET;
      battery_mv_reg <= fgr_pkg::MV_RESET;
    end
  end

  // [RL9] Strobe lasts one cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clear_pulse <= 1'b0;
    end else begin
      clear_pulse <= clear_hit;
    end
  end

  // Sleep interval timer; restarts whenever sleep is left or retimed
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sleep_count_reg <= 40'h00_0000_0000;
      sleep_update <= 1'b0;
    end else if (!(gauge_control_reg[fgr_pkg::CTRL_ENABLE_BIT] &&
                   gauge_control_reg[fgr_pkg::CTRL_SLEEP_BIT]) ||
                 wr_control) begin
      sleep_count_reg <= 40'h00_0000_0000;
      sleep_update <= 1'b0;
    end else if (sleep_count_reg >= sleep_limit - 40'h00_0000_0001) begin
      sleep_count_reg <= 40'h00_0000_0000;
      sleep_update <= 1'b1;
    end else begin
      sleep_count_reg <= sleep_count_reg + 40'h00_0000_0001;
      sleep_update <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gauge_enable <= 1'b0;
      sleep_mode <= 1'b0;
      sleep_period_long <= 1'b0;
    end else begin
      gauge_enable <= gauge_control_reg[fgr_pkg::CTRL_ENABLE_BIT];
      sleep_mode <= gauge_control_reg[fgr_pkg::CTRL_SLEEP_BIT];
      sleep_period_long <= gauge_control_reg[fgr_pkg::CTRL_PERIOD_BIT];
    end
  end

  // Read path, one cycle latency
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= fgr_pkg::READ_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          // [RL1] Bit 7 reads zero
          fgr_pkg::ADDR_CHARGE: reg_rdata <= {1'b0, charge_percent_reg};
          // [RL2] Upper voltage bits
          fgr_pkg::ADDR_MV_HIGH:
            reg_rdata <= battery_mv_reg[12:fgr_pkg::MV_SPLIT];
          // [RL3] Lower bits left-aligned
          fgr_pkg::ADDR_MV_LOW:
            reg_rdata <= {battery_mv_reg[fgr_pkg::MV_SPLIT-1:0], 3'h0};
          // [RL10] Unused bits zero
          fgr_pkg::ADDR_CONTROL: reg_rdata <= {5'h00, gauge_control_reg};
          // [RL9] Clear reads zero
          fgr_pkg::ADDR_CLEAR: reg_rdata <= fgr_pkg::READ_ZERO;
          default: reg_rdata <= fgr_pkg::READ_ZERO;
        endcase
      end
    end
  end
endmodule

// [sim/fgr_regs_sva.sv]
`timescale 1ns/100ps
module fgr_chk (
  input wire logic clk_sys, rstn, reg_wr, reg_rd, meas_valid, clear_pulse,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic [12:0] meas_mv,
  input wire logic gauge_enable, sleep_mode, sleep_period_long,
  input wire logic sleep_update
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire ctl = reg_wr && reg_addr == 8'h24;
  wire clr = reg_wr && reg_addr == 8'h25 && reg_wdata[7];
  AST_CHG: assert property (reg_rd && reg_addr == 8'h21 |=>
    reg_rdata <= 8'h64) else $error("charge over limit");
  AST_MVH: assert property (meas_valid ##1 !meas_valid && !reg_wr ##1
    reg_rd && reg_addr == 8'h22 && !meas_valid && !reg_wr |=>
    reg_rdata == $past(meas_mv[12:5], 3)) else $error("high byte wrong");
  AST_MVL: assert property (reg_rd && reg_addr == 8'h23 |=>
    reg_rdata[2:0] == 3'h0) else $error("low byte spare bits set");
  AST_EN: assert property (ctl |=> ##1
    gauge_enable == $past(reg_wdata[0], 2)) else $error("enable wrong");
  AST_SLP: assert property (ctl |=> ##1
    sleep_mode == $past(reg_wdata[1], 2)) else $error("sleep wrong");
  AST_PER: assert property (ctl |=> ##1
    sleep_period_long == $past(reg_wdata[2], 2)) else $error("period wrong");
  AST_CLR: assert property (clr |=> clear_pulse)
    else $error("no clear pulse");
  AST_ONE: assert property (clear_pulse |-> $past(clr))
    else $error("stray clear pulse");
  AST_ZERO: assert property (reg_rd && (reg_addr < 8'h21 ||
    reg_addr > 8'h24) |=> reg_rdata == 8'h00) else $error("read not zero");
  AST_UPD: assert property (sleep_update |-> gauge_enable && sleep_mode)
    else $error("sleep update while not sleeping");
endmodule
bind fgr_regs fgr_chk chk_u (.clk_sys, .rstn, .reg_wr, .reg_rd, .meas_valid,
  .clear_pulse, .reg_addr, .reg_wdata, .reg_rdata, .meas_mv, .gauge_enable,
  .sleep_mode, .sleep_period_long, .sleep_update);

// [sim/fgr_meas_src.sv]
`timescale 1ns/100ps
module fgr_meas_src (
  input wire logic clk_sys, // System clock
  output logic meas_valid, // Result strobe
  output logic [6:0] meas_charge, // Percent
  output logic [12:0] meas_mv // Millivolts
);
  initial meas_valid = 1'b0;
  task automatic put(input logic [6:0] c, input logic [12:0] mv);
    @(negedge clk_sys);
    meas_valid = 1'b1;
    meas_charge = c;
    meas_mv = mv;
    @(negedge clk_sys);
    meas_valid = 1'b0;
    // Data is only good with the strobe
    meas_charge = ~c;
    meas_mv = ~mv;
  endtask
endmodule

// [sim/fgr_regs_tb.sv]
`timescale 1ns/100ps
module fgr_regs_tb;
  logic clk_sys, rstn, reg_wr, reg_rd, reg_rvalid, meas_valid, clear_pulse;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic gauge_enable, sleep_mode, period, sleep_update;
  logic [6:0] meas_charge;
  logic [12:0] meas_mv;
  logic [12:0] mv = 13'h1ABC;
  int bad_count = 0;
  int num_checks = 0;
  fgr_regs #(.SLEEP_SHORT_CYC(40'h14), .SLEEP_LONG_CYC(40'h50)) dut_u (
    .clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_rvalid, .meas_valid, .meas_charge, .meas_mv, .gauge_enable,
    .sleep_mode, .sleep_period_long(period), .clear_pulse, .sleep_update);
  fgr_meas_src src_u (.clk_sys, .meas_valid, .meas_charge, .meas_mv);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [8:0] s, e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch reg %h exp %h got %h", reg_addr, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(negedge clk_sys);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk({reg_rvalid, reg_rdata}, {1'b1, e});
  endtask
  // Cycles between two sleep update pulses, sampled at the falling edge
  task automatic gap(input int e);
    int n;
    n = 0;
    while (!sleep_update && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (!sleep_update && n < 300);
    chk(9'(n), 9'(e));
  endtask
  task automatic close_out;
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = 19'h0;
    repeat (16) @(negedge clk_sys);
    rstn = 1'b1;
    for (int a = 32; a < 39; a++) rd(8'(a), 8'h00);
    src_u.put(7'h7F, mv);
    rd(8'h22, 8'(mv / 32));
    rd(8'h23, 8'(mv % 32 * 8));
    for (int a = 33; a < 36; a++) wr(8'(a), 8'hFF);
    rd(8'h21, 8'h64);
    rd(8'h22, 8'(mv / 32));
    rd(8'h23, 8'(mv % 32 * 8));
    for (int i = 0; i < 3; i++) begin
      wr(8'h24, 8'hF8 | 8'(1 << i));
      rd(8'h24, 8'(1 << i));
      chk({6'h0, period, sleep_mode, gauge_enable}, 9'(1 << i));
    end
    wr(8'h24, 8'h03);
    gap(20);
    wr(8'h24, 8'h07);
    gap(80);
    wr(8'h25, 8'h7F);
    rd(8'h23, 8'(mv % 32 * 8));
    wr(8'h25, 8'h80);
    for (int a = 33; a < 36; a++) rd(8'(a), 8'h00);
    close_out();
  end
  // Whole sequence needs well under 1000 cycles
  initial begin
    #20000;
    bad_count++;
    close_out();
  end
endmodule
